// >>> shared/ivt_pkg.sv
// Purpose: constants for the input voltage start/stop threshold block
// Assumes: command codes and reset values as seen by the bus host
// Notes:   all thresholds count 250 mV steps, ratio counts 0.001 steps
package ivt_pkg;
  // ****************************************
  // command codes
  // ****************************************
  localparam logic [7:0]  CMD_FB_RATIO   = 8'h29;
  localparam logic [7:0]  CMD_VIN_START  = 8'h35;
  localparam logic [7:0]  CMD_VIN_STOP   = 8'h36;
  // ****************************************
  // fields and reset values
  // ****************************************
  localparam int          DATA_W         = 16;
  localparam int          FIELD_W        = 12;
  localparam logic [15:0] RST_FB_RATIO   = 16'h0359;
  localparam logic [15:0] RST_VIN_START  = 16'h001d;
  localparam logic [15:0] RST_VIN_STOP   = 16'h001b;
  localparam logic [3:0]  RO_BITS_VALUE  = 4'h0;
  // ****************************************
  // conversion state
  // ****************************************
  typedef enum logic {
    IVT_STOPPED = 1'b0,
    IVT_RUNNING = 1'b1
  } ivt_run_t;
endpackage

// >>> rtl/ivt_cmd_reg.sv
// Purpose: one 16-bit direct-format command with a 12-bit stored field
// Assumes: write strobe and data come from logic on the same clock
// Notes:   upper four bits read as zero and ignore writes
`timescale 1ns/1ps
module ivt_cmd_reg #(
  parameter logic [15:0] RESET_VAL = 16'h0000
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rstn,
  // write side
  input  wire logic        wr_en,
  input  wire logic [15:0] wdata,
  // stored value
  output logic      [15:0] value
);
  typedef struct packed {
    logic [ivt_pkg::FIELD_W-1:0] field;
    logic                        seen_wr;
  } ivt_reg_state_t;

  ivt_reg_state_t state;
  ivt_reg_state_t next_state;

  always_comb begin
    next_state = state;
    if (wr_en) begin
      next_state.field   = wdata[ivt_pkg::FIELD_W-1:0];
      next_state.seen_wr = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state.field   <= RESET_VAL[ivt_pkg::FIELD_W-1:0];
      state.seen_wr <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  assign value = {ivt_pkg::RO_BITS_VALUE, state.field};

  // ****************************************
  // checks
  // ****************************************
  property p_reg_default;
    @(posedge clock) disable iff (!rstn)
      !state.seen_wr |-> value == RESET_VAL;
  endproperty
  a_reg_default: assert property (p_reg_default)
    else $error("command lost its reset value before any write");

  property p_reg_write;
    @(posedge clock) disable iff (!rstn)
      wr_en |=> value == {4'h0, $past(wdata[11:0])} && value[15:12] == 4'h0;
  endproperty
  a_reg_write: assert property (p_reg_write)
    else $error("write not stored as low twelve bits only");
endmodule

// >>> rtl/ivt_thresholds.sv
// Purpose: input voltage start/stop thresholds and feedback ratio
// Assumes: vin_level is a same-clock measurement in 250 mV steps
// Notes:   hysteresis between start and stop keeps conversion stable
//
// Function
// - feedback ratio unsigned in 0.001 steps, resets 0x0359
// - start only at start threshold with other conditions
// - start threshold 250 mV steps, resets 0x001d
// - running conversion stops at stop threshold
// - stop threshold 250 mV steps, resets 0x001b
`timescale 1ns/1ps
module ivt_thresholds (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rstn,
  // command port from bus host logic
  input  wire logic [7:0]  cmd_code,
  input  wire logic        cmd_wr,
  input  wire logic        cmd_rd,
  input  wire logic [15:0] cmd_wdata,
  output logic      [15:0] rd_data,
  output logic             rd_ack,
  output logic             cmd_nack,
  // input voltage measurement and other start conditions
  input  wire logic [15:0] vin_level,
  input  wire logic        vin_valid,
  input  wire logic        other_ok,
  // converter control
  output logic             conv_enable,
  output logic      [15:0] fb_ratio
);
  // ****************************************
  // command storage
  // ****************************************
  logic [15:0] start_thr;
  logic [15:0] stop_thr;
  logic [15:0] ratio_val;
  logic        hit_ratio;
  logic        hit_start;
  logic        hit_stop;
  logic        hit_any;

  assign hit_ratio = cmd_code == ivt_pkg::CMD_FB_RATIO;
  assign hit_start = cmd_code == ivt_pkg::CMD_VIN_START;
  assign hit_stop  = cmd_code == ivt_pkg::CMD_VIN_STOP;
  assign hit_any   = hit_ratio | hit_start | hit_stop;

  ivt_cmd_reg #(.RESET_VAL(ivt_pkg::RST_FB_RATIO)) u_ratio (
    .clock (clock),
    .rstn  (rstn),
    .wr_en (cmd_wr & hit_ratio),
    .wdata (cmd_wdata),
    .value (ratio_val)
  );

  ivt_cmd_reg #(.RESET_VAL(ivt_pkg::RST_VIN_START)) u_start (
    .clock (clock),
    .rstn  (rstn),
    .wr_en (cmd_wr & hit_start),
    .wdata (cmd_wdata),
    .value (start_thr)
  );

  ivt_cmd_reg #(.RESET_VAL(ivt_pkg::RST_VIN_STOP)) u_stop (
    .clock (clock),
    .rstn  (rstn),
    .wr_en (cmd_wr & hit_stop),
    .wdata (cmd_wdata),
    .value (stop_thr)
  );

  assign fb_ratio = ratio_val;

  // ****************************************
  // run state and read answers
  // ****************************************
  typedef struct packed {
    ivt_pkg::ivt_run_t run;
    logic [15:0]       rd_data;
    logic              rd_ack;
    logic              cmd_nack;
  } ivt_top_state_t;

  ivt_top_state_t state;
  ivt_top_state_t next_state;
  logic           reach_start;
  logic           reach_stop;

  assign reach_start = vin_valid && vin_level >= start_thr;
  assign reach_stop  = vin_valid && vin_level <= stop_thr;

  always_comb begin
    next_state          = state;
    next_state.rd_ack   = 1'b0;
    next_state.cmd_nack = 1'b0;
    case (state.run)
      ivt_pkg::IVT_STOPPED: begin
        if (reach_start && other_ok) begin
          next_state.run = ivt_pkg::IVT_RUNNING;
        end
      end
      ivt_pkg::IVT_RUNNING: begin
        if (reach_stop || !other_ok) begin
          next_state.run = ivt_pkg::IVT_STOPPED;
        end
      end
      default: begin
        next_state.run = ivt_pkg::IVT_STOPPED;
      end
    endcase
    if (cmd_rd) begin
      next_state.rd_ack = hit_any;
      if (hit_ratio) begin
        next_state.rd_data = ratio_val;
      end else if (hit_start) begin
        next_state.rd_data = start_thr;
      end else if (hit_stop) begin
        next_state.rd_data = stop_thr;
      end else begin
        next_state.rd_data = 16'h0000;
      end
    end
    if ((cmd_rd || cmd_wr) && !hit_any) begin
      next_state.cmd_nack = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state.run      <= ivt_pkg::IVT_STOPPED;
      state.rd_data  <= 16'h0000;
      state.rd_ack   <= 1'b0;
      state.cmd_nack <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  assign conv_enable = state.run == ivt_pkg::IVT_RUNNING;
  assign rd_data     = state.rd_data;
  assign rd_ack      = state.rd_ack;
  assign cmd_nack    = state.cmd_nack;

  // ****************************************
  // checks
  // ****************************************
  property p_start;
    @(posedge clock) disable iff (!rstn)
      !conv_enable && reach_start && other_ok |=> conv_enable;
  endproperty
  a_start: assert property (p_start)
    else $error("conversion did not start at start threshold");

  property p_no_early_start;
    @(posedge clock) disable iff (!rstn)
      !conv_enable && !(reach_start && other_ok) |=> !conv_enable;
  endproperty
  a_no_early_start: assert property (p_no_early_start)
    else $error("conversion started without a start crossing");

  property p_stop;
    @(posedge clock) disable iff (!rstn)
      conv_enable && reach_stop |=> !conv_enable;
  endproperty
  a_stop: assert property (p_stop)
    else $error("conversion kept running at stop threshold");

  property p_hold;
    @(posedge clock) disable iff (!rstn)
      conv_enable && !reach_stop && other_ok |=> conv_enable;
  endproperty
  a_hold: assert property (p_hold)
    else $error("conversion stopped above stop threshold");

  property p_read_ratio;
    @(posedge clock) disable iff (!rstn)
      cmd_rd && hit_ratio |=> rd_ack && rd_data == $past(ratio_val);
  endproperty
  a_read_ratio: assert property (p_read_ratio)
    else $error("ratio read returned wrong value");

  property p_read_thr;
    @(posedge clock) disable iff (!rstn)
      cmd_rd && (hit_start || hit_stop) |=> rd_ack && rd_data[15:12] == 4'h0;
  endproperty
  a_read_thr: assert property (p_read_thr)
    else $error("threshold read showed nonzero upper bits");

  property p_other_lost;
    @(posedge clock) disable iff (!rstn)
      conv_enable && !other_ok |=> !conv_enable;
  endproperty
  a_other_lost: assert property (p_other_lost)
    else $error("conversion kept running without other conditions");

  property p_stop_no_valid;
    @(posedge clock) disable iff (!rstn)
      conv_enable && !vin_valid && other_ok |=> conv_enable;
  endproperty
  a_stop_no_valid: assert property (p_stop_no_valid)
    else $error("conversion stopped without a valid measurement");

  property p_read_start;
    @(posedge clock) disable iff (!rstn)
      cmd_rd && hit_start |=> rd_ack && rd_data == $past(start_thr);
  endproperty
  a_read_start: assert property (p_read_start)
    else $error("start threshold read returned wrong value");

  property p_read_stop;
    @(posedge clock) disable iff (!rstn)
      cmd_rd && hit_stop |=> rd_ack && rd_data == $past(stop_thr);
  endproperty
  a_read_stop: assert property (p_read_stop)
    else $error("stop threshold read returned wrong value");

  property p_ratio_write;
    @(posedge clock) disable iff (!rstn)
      cmd_wr && hit_ratio |=> fb_ratio == {4'h0, $past(cmd_wdata[11:0])};
  endproperty
  a_ratio_write: assert property (p_ratio_write)
    else $error("ratio output does not follow written value");
endmodule

// >>> test/ivt_host.sv
// Purpose: command host model for the threshold block
// Assumes: one-cycle strobes launched just after a rising edge
// Notes:   callers choose threshold and ratio values; the bench also sends one with upper bits set
`timescale 1ns/1ps
module ivt_host (
  // clock
  input  wire logic        clock,
  // command port
  output logic      [7:0]  cmd_code,
  output logic             cmd_wr,
  output logic             cmd_rd,
  output logic      [15:0] cmd_wdata
);
  initial begin
    cmd_code = 8'h00;
    cmd_wr = 1'b0;
    cmd_rd = 1'b0;
    cmd_wdata = 16'h0000;
  end
  // ****
  // write: one-cycle cmd_wr strobe with the caller's code and data, then data driven inverted
  // ****
  task automatic wr(input logic [7:0] code, input logic [15:0] data);
    @(posedge clock);
    cmd_code <= code;
    cmd_wdata <= data;
    cmd_wr <= 1'b1;
    @(posedge clock);
    cmd_wr <= 1'b0;
    cmd_wdata <= ~data;
  endtask
  task automatic rd(input logic [7:0] code);
    @(posedge clock);
    cmd_code <= code;
    cmd_rd <= 1'b1;
    @(posedge clock);
    cmd_rd <= 1'b0;
  endtask
endmodule

// >>> test/ivt_thresholds_tb.sv
// Purpose: self-checking bench for the threshold block
// Assumes: host model drives the command port
// Notes:   measurement inputs are driven here
`timescale 1ns/1ps
module ivt_thresholds_tb;
  logic        clock = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  cmd_code;
  logic        cmd_wr;
  logic        cmd_rd;
  logic [15:0] cmd_wdata;
  logic [15:0] rd_data;
  logic        rd_ack;
  logic        cmd_nack;
  logic [15:0] vin_level = 16'h0000;
  logic        vin_valid = 1'b0;
  logic        other_ok = 1'b0;
  logic        conv_enable;
  logic [15:0] fb_ratio;
  int          n_errors = 0;
  int          checks = 0;
  int          cycles = 0;

  ivt_host ivt_host_i (.clock(clock), .cmd_code(cmd_code),
    .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_wdata(cmd_wdata));
  ivt_thresholds ivt_thresholds_i (.clock(clock), .rstn(rstn),
    .cmd_code(cmd_code), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
    .cmd_wdata(cmd_wdata), .rd_data(rd_data), .rd_ack(rd_ack),
    .cmd_nack(cmd_nack), .vin_level(vin_level), .vin_valid(vin_valid),
    .other_ok(other_ok), .conv_enable(conv_enable), .fb_ratio(fb_ratio));

  always #20 clock = ~clock;

  task automatic test_done();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      n_errors++;
      test_done();
    end
  end

  task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // answer: {ack, nack, data}
  task automatic rd_chk(input logic [7:0] code, input logic [17:0] exp);
    ivt_host_i.rd(code);
    #1;
    chk({rd_ack, cmd_nack, rd_data}, exp);
  endtask
  task automatic run_chk(input logic [15:0] lvl, input logic v,
                         input logic ok, input logic exp);
    @(posedge clock);
    vin_level <= lvl;
    vin_valid <= v;
    other_ok <= ok;
    repeat (2) @(posedge clock);
    #1;
    chk({17'h0, conv_enable}, {17'h0, exp});
  endtask

  initial begin
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
    #1;
    chk({2'b00, fb_ratio}, 18'h00359);
    rd_chk(ivt_pkg::CMD_FB_RATIO, 18'h20359);
    rd_chk(ivt_pkg::CMD_VIN_START, 18'h2001d);
    rd_chk(ivt_pkg::CMD_VIN_STOP, 18'h2001b);
    run_chk(16'h001c, 1'b1, 1'b1, 1'b0);
    run_chk(16'h001d, 1'b1, 1'b1, 1'b1);
    run_chk(16'h001b, 1'b1, 1'b1, 1'b0);
    ivt_host_i.wr(ivt_pkg::CMD_VIN_START, 16'hf030);
    ivt_host_i.wr(ivt_pkg::CMD_VIN_STOP, 16'h0020);
    ivt_host_i.wr(ivt_pkg::CMD_FB_RATIO, 16'h02ee);
    ivt_host_i.wr(8'h40, 16'h0123);
    #1;
    chk({17'h0, cmd_nack}, 18'h00001);
    rd_chk(ivt_pkg::CMD_VIN_START, 18'h20030);
    rd_chk(ivt_pkg::CMD_VIN_STOP, 18'h20020);
    chk({2'b00, fb_ratio}, 18'h002ee);
    rd_chk(8'h40, 18'h10000);
    run_chk(16'h0030, 1'b0, 1'b1, 1'b0);
    run_chk(16'h002f, 1'b1, 1'b1, 1'b0);
    run_chk(16'h0030, 1'b1, 1'b1, 1'b1);
    run_chk(16'h0021, 1'b1, 1'b1, 1'b1);
    run_chk(16'h0020, 1'b1, 1'b1, 1'b0);
    run_chk(16'h002f, 1'b1, 1'b1, 1'b0);
    run_chk(16'h0030, 1'b1, 1'b0, 1'b0);
    run_chk(16'h0030, 1'b1, 1'b1, 1'b1);
    run_chk(16'h0010, 1'b0, 1'b1, 1'b1);
    run_chk(16'h0030, 1'b1, 1'b0, 1'b0);
    @(posedge clock);
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    #1;
    chk({1'b0, conv_enable, fb_ratio}, 18'h00359);
    rd_chk(ivt_pkg::CMD_VIN_START, 18'h2001d);
    rd_chk(ivt_pkg::CMD_VIN_STOP, 18'h2001b);
    test_done();
  end
endmodule
